// ===== design/blpoc_map.vh
`ifndef BLPOC_MAP_VH
`define BLPOC_MAP_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
// The printed offset A3h is not word aligned, so each printed offset is an index.
// Its byte address is four times the index.
`define BLPOC_IDX_PHASE_FREQ   8'hA3
`define BLPOC_IDX_RESOL_OUT    8'hA4
`define BLPOC_ADDR_W           12
`define BLPOC_ADDR_PHASE_FREQ  12'h28C
`define BLPOC_ADDR_RESOL_OUT   12'h290

// ----------------------------------------------------------------
// Reset values (not documented, neutral defaults)
// ----------------------------------------------------------------
`define BLPOC_RST_PHASE_FREQ   8'h00
`define BLPOC_RST_RESOL_OUT    8'h00

// ----------------------------------------------------------------
// Field positions, first register
// ----------------------------------------------------------------
`define BLPOC_LOCKOUT_HI       7
`define BLPOC_LOCKOUT_LO       6
`define BLPOC_PHASE_EN_BIT     5
`define BLPOC_RATE_HI          4
`define BLPOC_RATE_LO          0

// ----------------------------------------------------------------
// Field positions, second register
// ----------------------------------------------------------------
`define BLPOC_RESOL_HI         7
`define BLPOC_RESOL_LO         6
`define BLPOC_RSET_EN_BIT      5
`define BLPOC_FAULT_LVL_BIT    4
`define BLPOC_SLOPE_LO_BIT     3
`define BLPOC_HEADROOM_HI      2
`define BLPOC_HEADROOM_LO      0

// ----------------------------------------------------------------
// Decode figures
// ----------------------------------------------------------------
`define BLPOC_HEADROOM_STEP_MV 10'd125
`define BLPOC_LOCKOUT_STEP_DV  7'd27
`define BLPOC_SLOPE_STEP_25    7'd20
`define BLPOC_SLOPE_STEP_50    7'd10
`define BLPOC_RES_MIN_BASE     4'd8
`define BLPOC_RES_MAX_BASE     4'd10

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define BLPOC_RESP_OKAY        2'b00
`define BLPOC_RESP_SLVERR      2'b10

`endif

// ===== design/blpoc_code_decode.v
`timescale 1ns/1ps
`include "blpoc_map.vh"

module blpoc_code_decode (
   // Stored codes
   input  wire [1:0] lockout_code,
   input  wire [1:0] resol_code,
   input  wire [1:0] slope_code,
   input  wire       slope_mode_25,
   input  wire [2:0] headroom_code,
   // Decoded figures
   output reg  [6:0] lockout_dv,
   output reg  [3:0] resol_min_bits,
   output reg  [3:0] resol_max_bits,
   output reg  [6:0] slope_eighth_pct,
   output reg  [9:0] headroom_mv
);

   // Pure table decode; the caller registers the results
   always @* begin
      lockout_dv       = `BLPOC_LOCKOUT_STEP_DV * {5'd0, lockout_code};      // R10
      resol_min_bits   = `BLPOC_RES_MIN_BASE + {2'd0, resol_code};           // R3
      resol_max_bits   = `BLPOC_RES_MAX_BASE + {2'd0, resol_code};           // R3
      slope_eighth_pct = (slope_mode_25 ? `BLPOC_SLOPE_STEP_25 : `BLPOC_SLOPE_STEP_50)
                         * ({5'd0, slope_code} + 7'd1);                     // R8
      headroom_mv      = `BLPOC_HEADROOM_STEP_MV * ({7'd0, headroom_code} + 10'd1); // R7
   end

endmodule

// ===== design/blpoc_config_bank.v
// Functional notes
// (R1) Bit 5 of first register enables phase-shifted dimming; clear means in-phase.
// (R2) Bits 4:0 of first register select the dimming output frequency code.
// (R3) Second register bits 7:6 select resolution, 8..10 bits plus code.
// (R4) Second register bit 5 adds the external set resistor to current setting.
// (R5) Second register bit 4 selects string fault level: 0 low, 1 high.
// (R6) Second register bit 3 is the low bit of the current slope field.
// (R7) Second register bits 2:0 select headroom, 125 mV per step from 125 mV.
// (R8) Full slope code gives equal steps, doubled in 25% mode versus 50%.
// (R9) With adaptive boost, headroom code regulates boost after startup.
// (R10) First register bits 7:6 select lockout threshold; code zero disables.
`timescale 1ns/1ps
`include "blpoc_map.vh"

module blpoc_config_bank #(
   parameter [7:0] RESET_PHASE_FREQ = `BLPOC_RST_PHASE_FREQ,
   parameter [7:0] RESET_RESOL_OUT  = `BLPOC_RST_RESOL_OUT
) (
   // Clock and reset
   input  wire                     aclk,
   input  wire                     aresetn,
   // AXI4-Lite write address
   input  wire [`BLPOC_ADDR_W-1:0] s_axi_awaddr,
   input  wire                     s_axi_awvalid,
   output wire                     s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   input  wire                     s_axi_wvalid,
   output wire                     s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]               s_axi_bresp,
   output wire                     s_axi_bvalid,
   input  wire                     s_axi_bready,
   // AXI4-Lite read address
   input  wire [`BLPOC_ADDR_W-1:0] s_axi_araddr,
   input  wire                     s_axi_arvalid,
   output wire                     s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0]              s_axi_rdata,
   output wire [1:0]               s_axi_rresp,
   output wire                     s_axi_rvalid,
   input  wire                     s_axi_rready,
   // Neighbouring settings, same clock
   input  wire                     slope_upper_bit,
   input  wire                     slope_mode_25,
   input  wire                     adaptive_boost_enable,
   input  wire                     boost_startup_done,
   // Raw field outputs
   output wire [1:0]               input_lockout_threshold_sel,
   output wire                     phase_shift_dimming_enable,
   output wire [4:0]               dimming_rate_sel,
   output wire [1:0]               resolution_sel,
   output wire                     current_set_resistor_enable,
   output wire                     string_fault_level_sel,
   output wire [2:0]               sink_headroom_sel,
   // Decoded settings
   output wire                     lockout_enable,
   output wire [6:0]               lockout_level_dv,
   output wire [3:0]               resolution_min_bits,
   output wire [3:0]               resolution_max_bits,
   output wire [1:0]               current_slope_code,
   output wire [6:0]               current_slope_eighth_pct,
   output wire [9:0]               headroom_mv,
   output wire                     headroom_regulate,
   output wire [9:0]               headroom_target_mv
);

   // ----------------------------------------------------------------
   // Stored configuration
   // ----------------------------------------------------------------
   reg  [7:0]               phase_freq_r;
   reg  [7:0]               resol_out_r;

   // ----------------------------------------------------------------
   // Bus state
   // ----------------------------------------------------------------
   reg                      awready_r;
   reg                      wready_r;
   reg                      bvalid_r;
   reg  [1:0]               bresp_r;
   reg                      arready_r;
   reg                      rvalid_r;
   reg  [1:0]               rresp_r;
   reg  [31:0]              rdata_r;
   reg  [`BLPOC_ADDR_W-1:0] waddr_r;
   reg  [7:0]               wbyte_r;
   reg                      wlane_r;
   reg                      aw_full_r;
   reg                      w_full_r;

   // ----------------------------------------------------------------
   // Registered decoded outputs
   // ----------------------------------------------------------------
   reg                      lockout_en_r;
   reg  [6:0]               lockout_dv_r;
   reg  [3:0]               res_min_r;
   reg  [3:0]               res_max_r;
   reg  [1:0]               slope_code_r;
   reg  [6:0]               slope_pct_r;
   reg  [9:0]               headroom_mv_r;
   reg                      regulate_r;
   reg  [9:0]               target_mv_r;

   wire [6:0]               dec_lockout_dv;
   wire [3:0]               dec_res_min;
   wire [3:0]               dec_res_max;
   wire [6:0]               dec_slope_pct;
   wire [9:0]               dec_headroom_mv;
   wire [1:0]               slope_full;
   wire                     aw_take;
   wire                     w_take;
   wire                     ar_take;
   wire                     do_write;

   assign aw_take  = s_axi_awvalid & awready_r;
   assign w_take   = s_axi_wvalid & wready_r;
   assign ar_take  = s_axi_arvalid & arready_r;
   assign do_write = aw_full_r & w_full_r & ~bvalid_r;

   // Upper slope bit lives in a neighbouring register
   assign slope_full = {slope_upper_bit, resol_out_r[`BLPOC_SLOPE_LO_BIT]};   // R6

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   // Address and data are caught in either order; ready stays low until
   // the response is taken, so only one write is ever in flight.
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_r    <= 1'b0;
         wready_r     <= 1'b0;
         aw_full_r    <= 1'b0;
         w_full_r     <= 1'b0;
         waddr_r      <= {`BLPOC_ADDR_W{1'b0}};
         wbyte_r      <= 8'h00;
         wlane_r      <= 1'b0;
         bvalid_r     <= 1'b0;
         bresp_r      <= `BLPOC_RESP_OKAY;
         phase_freq_r <= RESET_PHASE_FREQ;
         resol_out_r  <= RESET_RESOL_OUT;
      end else begin
         if (!aw_full_r && !bvalid_r && !awready_r) begin
            awready_r <= 1'b1;
         end
         if (!w_full_r && !bvalid_r && !wready_r) begin
            wready_r <= 1'b1;
         end
         if (aw_take) begin
            waddr_r   <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (w_take) begin
            wbyte_r  <= s_axi_wdata[7:0];
            wlane_r  <= s_axi_wstrb[0];
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= `BLPOC_RESP_OKAY;
            // Byte lane 0 carries the whole 8-bit register
            case (waddr_r & ~{{(`BLPOC_ADDR_W-2){1'b0}}, 2'b11})
               `BLPOC_ADDR_PHASE_FREQ: begin
                  if (wlane_r) begin
                     phase_freq_r <= wbyte_r;                   // R1 R2 R10
                  end
               end
               `BLPOC_ADDR_RESOL_OUT: begin
                  if (wlane_r) begin
                     resol_out_r <= wbyte_r;                    // R3 R4 R5 R6 R7
                  end
               end
               default: begin
                  bresp_r <= `BLPOC_RESP_SLVERR;
               end
            endcase
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Answer one cycle after the address is taken; upper bits read zero.
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= `BLPOC_RESP_OKAY;
         rdata_r   <= 32'h00000000;
      end else begin
         if (!rvalid_r && !arready_r) begin
            arready_r <= 1'b1;
         end
         if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            case (s_axi_araddr & ~{{(`BLPOC_ADDR_W-2){1'b0}}, 2'b11})
               `BLPOC_ADDR_PHASE_FREQ: begin
                  rdata_r <= {24'h000000, phase_freq_r};
                  rresp_r <= `BLPOC_RESP_OKAY;
               end
               `BLPOC_ADDR_RESOL_OUT: begin
                  rdata_r <= {24'h000000, resol_out_r};
                  rresp_r <= `BLPOC_RESP_OKAY;
               end
               default: begin
                  rdata_r <= 32'h00000000;
                  rresp_r <= `BLPOC_RESP_SLVERR;
               end
            endcase
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Code decode
   // ----------------------------------------------------------------
   blpoc_code_decode u_decode (
      .lockout_code     (phase_freq_r[`BLPOC_LOCKOUT_HI:`BLPOC_LOCKOUT_LO]),
      .resol_code       (resol_out_r[`BLPOC_RESOL_HI:`BLPOC_RESOL_LO]),
      .slope_code       (slope_full),
      .slope_mode_25    (slope_mode_25),
      .headroom_code    (resol_out_r[`BLPOC_HEADROOM_HI:`BLPOC_HEADROOM_LO]),
      .lockout_dv       (dec_lockout_dv),
      .resol_min_bits   (dec_res_min),
      .resol_max_bits   (dec_res_max),
      .slope_eighth_pct (dec_slope_pct),
      .headroom_mv      (dec_headroom_mv)
   );

   // Decoded figures lag the stored code by one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         lockout_en_r  <= 1'b0;
         lockout_dv_r  <= 7'h00;
         res_min_r     <= 4'h0;
         res_max_r     <= 4'h0;
         slope_code_r  <= 2'h0;
         slope_pct_r   <= 7'h00;
         headroom_mv_r <= 10'h000;
         regulate_r    <= 1'b0;
         target_mv_r   <= 10'h000;
      end else begin
         lockout_en_r  <= |phase_freq_r[`BLPOC_LOCKOUT_HI:`BLPOC_LOCKOUT_LO]; // R10
         lockout_dv_r  <= dec_lockout_dv;                                   // R10
         res_min_r     <= dec_res_min;                                      // R3
         res_max_r     <= dec_res_max;                                      // R3
         slope_code_r  <= slope_full;                                       // R8
         slope_pct_r   <= dec_slope_pct;                                    // R8
         headroom_mv_r <= dec_headroom_mv;                                  // R7
         // Target only while adaptive boost runs past its startup
         regulate_r    <= adaptive_boost_enable & boost_startup_done;       // R9
         target_mv_r   <= (adaptive_boost_enable & boost_startup_done)
                          ? dec_headroom_mv : 10'h000;                      // R9
      end
   end

   // ----------------------------------------------------------------
   // Output wiring, all from flip-flops
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   assign input_lockout_threshold_sel = phase_freq_r[`BLPOC_LOCKOUT_HI:`BLPOC_LOCKOUT_LO]; // R10
   assign phase_shift_dimming_enable  = phase_freq_r[`BLPOC_PHASE_EN_BIT];                 // R1
   assign dimming_rate_sel            = phase_freq_r[`BLPOC_RATE_HI:`BLPOC_RATE_LO];        // R2
   assign resolution_sel              = resol_out_r[`BLPOC_RESOL_HI:`BLPOC_RESOL_LO];       // R3
   assign current_set_resistor_enable = resol_out_r[`BLPOC_RSET_EN_BIT];                   // R4
   assign string_fault_level_sel      = resol_out_r[`BLPOC_FAULT_LVL_BIT];                 // R5
   assign sink_headroom_sel           = resol_out_r[`BLPOC_HEADROOM_HI:`BLPOC_HEADROOM_LO]; // R7

   assign lockout_enable           = lockout_en_r;
   assign lockout_level_dv         = lockout_dv_r;
   assign resolution_min_bits      = res_min_r;
   assign resolution_max_bits      = res_max_r;
   assign current_slope_code       = slope_code_r;
   assign current_slope_eighth_pct = slope_pct_r;
   assign headroom_mv              = headroom_mv_r;
   assign headroom_regulate        = regulate_r;
   assign headroom_target_mv       = target_mv_r;

endmodule

// ===== sim/blpoc_chk.sv
`timescale 1ns/1ps
`include "blpoc_map.vh"

module blpoc_chk (
   // Clock, reset and bus handshakes
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Settings in and out
   input wire        slope_upper_bit,
   input wire        slope_mode_25,
   input wire        adaptive_boost_enable,
   input wire        boost_startup_done,
   input wire [1:0]  input_lockout_threshold_sel,
   input wire [1:0]  resolution_sel,
   input wire [2:0]  sink_headroom_sel,
   input wire        lockout_enable,
   input wire [6:0]  lockout_level_dv,
   input wire [3:0]  resolution_min_bits,
   input wire [3:0]  resolution_max_bits,
   input wire [1:0]  current_slope_code,
   input wire [6:0]  current_slope_eighth_pct,
   input wire [9:0]  headroom_mv,
   input wire        headroom_regulate,
   input wire [9:0]  headroom_target_mv
);
   // Cycles since reset; decoders lag the fields, so $past is trusted late
   reg [1:0] up_r;
   always @(posedge aclk) begin
      if (!aresetn) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------------------------------
   // Decoded figures
   // ----------------------------------------------------------------
   headroom_step_a: assert property (up_r == 2'h3 |-> headroom_mv == 10'd125 *
      ({7'h0, $past(sink_headroom_sel)} + 10'd1)) else $error("headroom figure wrong");
   resol_bits_a: assert property (up_r == 2'h3 |-> resolution_min_bits ==
      4'd8 + $past(resolution_sel) && resolution_max_bits == 4'd10 + $past(resolution_sel))
      else $error("resolution bits wrong");
   lockout_level_a: assert property (up_r == 2'h3 |-> lockout_enable ==
      ($past(input_lockout_threshold_sel) != 2'h0) && lockout_level_dv ==
      7'd27 * {5'h0, $past(input_lockout_threshold_sel)}) else $error("lockout wrong");
   slope_upper_a: assert property (up_r == 2'h3 |-> current_slope_code[1] ==
      $past(slope_upper_bit)) else $error("slope upper bit wrong");
   slope_step_a: assert property (up_r == 2'h3 |-> current_slope_eighth_pct ==
      ({5'h0, current_slope_code} + 7'd1) * ($past(slope_mode_25) ? 7'd20 : 7'd10))
      else $error("slope magnitude wrong");
   boost_regulate_a: assert property (up_r == 2'h3 |-> headroom_regulate ==
      $past(adaptive_boost_enable && boost_startup_done) && headroom_target_mv ==
      (headroom_regulate ? headroom_mv : 10'h000)) else $error("headroom regulation wrong");
   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write answer dropped");
   rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read answer dropped");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read upper bits set");
   // Main scenarios
   cover property (s_axi_bvalid && s_axi_bresp == `BLPOC_RESP_SLVERR);
   cover property (headroom_regulate && sink_headroom_sel == 3'h7);
   cover property (slope_mode_25 && current_slope_code == 2'h3);
endmodule

bind blpoc_config_bank blpoc_chk blpoc_chk_inst (.*);

// ===== sim/blpoc_config_bank_bench.sv
`timescale 1ns/1ps
`include "blpoc_map.vh"

module blpoc_config_bank_bench;
   reg aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   reg [11:0] awa = 12'h000, ara = 12'h000;
   reg [31:0] wd = 32'h0;
   reg [3:0] ws = 4'h0;
   reg su = 1'b0, sm = 1'b0, abe = 1'b0, bsd = 1'b0;
   wire awr, wr_, bv, arr, rv;
   wire [1:0] br, rr, lk, rs, sl;
   wire [31:0] rd;
   wire ph, ri, fl, le, hr;
   wire [4:0] rt;
   wire [2:0] hs;
   wire [6:0] lv, sp;
   wire [3:0] rmn, rmx;
   wire [9:0] hm, ht;
   integer n_mismatch = 0, total_checks = 0, i;
   reg [7:0] d;
   reg [31:0] v;
   reg [1:0] r;
   always #2.5 aclk = ~aclk;
   blpoc_config_bank blpoc_config_bank_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .slope_upper_bit(su), .slope_mode_25(sm),
      .adaptive_boost_enable(abe), .boost_startup_done(bsd),
      .input_lockout_threshold_sel(lk), .phase_shift_dimming_enable(ph),
      .dimming_rate_sel(rt), .resolution_sel(rs), .current_set_resistor_enable(ri),
      .string_fault_level_sel(fl), .sink_headroom_sel(hs), .lockout_enable(le),
      .lockout_level_dv(lv), .resolution_min_bits(rmn), .resolution_max_bits(rmx),
      .current_slope_code(sl), .current_slope_eighth_pct(sp), .headroom_mv(hm),
      .headroom_regulate(hr), .headroom_target_mv(ht));
   // ----------------------------------------------------------------
   // Comparison and verdict
   // ----------------------------------------------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task stop_test;
      begin
         if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // Bus master: each channel held until its own ready edge
   // ----------------------------------------------------------------
   task axw(input [11:0] a, input [7:0] dat, input [3:0] s, output [1:0] resp);
      reg ad, dd;
      begin
         @(posedge aclk);
         awa <= a; wd <= {24'h0, dat}; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
         ad = 1'b0; dd = 1'b0;
         while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awr === 1'b1) begin ad = 1'b1; awv <= 1'b0; end
            if (!dd && wr_ === 1'b1) begin dd = 1'b1; wv <= 1'b0; end
         end
         while (bv !== 1'b1) @(posedge aclk);
         resp = br;
         bry <= 1'b0;
      end
   endtask
   task axr(input [11:0] a, output [31:0] dat, output [1:0] resp);
      begin
         @(posedge aclk);
         ara <= a; arv <= 1'b1; rry <= 1'b1;
         @(posedge aclk);
         while (arr !== 1'b1) @(posedge aclk);
         arv <= 1'b0;
         while (rv !== 1'b1) @(posedge aclk);
         dat = rd; resp = rr;
         rry <= 1'b0;
      end
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`BLPOC_ADDR_PHASE_FREQ, v, r); chk(v, `BLPOC_RST_PHASE_FREQ); chk(r, 2'b00);
      axr(`BLPOC_ADDR_RESOL_OUT, v, r); chk(v, `BLPOC_RST_RESOL_OUT); chk(r, 2'b00);
      chk(hm, 10'd125); chk(rmn, 4'd8);
      // Stepping by 25h walks every code of each field but the 5-bit rate field, which sees 8 of its 32
      for (i = 0; i < 8; i = i + 1) begin
         d = i * 8'h25;
         su <= i[0]; sm <= i[1]; abe <= i[2]; bsd <= i[0];
         axw(`BLPOC_ADDR_PHASE_FREQ, d, 4'hF, r); chk(r, 2'b00);
         axw(`BLPOC_ADDR_RESOL_OUT, ~d, 4'h1, r); chk(r, 2'b00);
         axr(`BLPOC_ADDR_PHASE_FREQ, v, r); chk(v, {24'h0, d});
         axr(`BLPOC_ADDR_RESOL_OUT, v, r); chk(v, {24'h0, ~d});
         repeat (3) @(posedge aclk);
         chk(lk, d[7:6]); chk(ph, d[5]); chk(rt, d[4:0]);
         chk(lv, 27 * d[7:6]); chk(le, d[7:6] != 2'h0);
         chk(rs, {~d[7:6]}); chk(rmn, 8 + (3 - d[7:6])); chk(rmx, 10 + (3 - d[7:6]));
         chk(ri, {~d[5]}); chk(fl, {~d[4]}); chk(hs, {~d[2:0]});
         chk(sl, {i[0], ~d[3]});
         chk(sp, ({i[0], ~d[3]} + 1) * (i[1] ? 20 : 10));
         chk(hm, 125 * ((7 - d[2:0]) + 1));
         chk(ht, (i[2] && i[0]) ? 125 * ((7 - d[2:0]) + 1) : 0);
         chk(hr, i[2] && i[0]);
      end
      // Disabled lane, low address bits, unmapped place
      axw(`BLPOC_ADDR_PHASE_FREQ, 8'h5A, 4'h0, r); chk(r, 2'b00);
      axr(`BLPOC_ADDR_PHASE_FREQ | 12'h003, v, r); chk(v, {24'h0, d});
      axw(12'h294, 8'hFF, 4'hF, r); chk(r, `BLPOC_RESP_SLVERR);
      axr(12'h294, v, r); chk(v, 32'h0); chk(r, `BLPOC_RESP_SLVERR);
      axr(`BLPOC_ADDR_RESOL_OUT, v, r); chk(v, {24'h0, ~d});
      // Reset in mid-run clears both registers
      @(posedge aclk); aresetn <= 1'b0;
      repeat (2) @(posedge aclk); aresetn <= 1'b1;
      axr(`BLPOC_ADDR_RESOL_OUT, v, r); chk(v, `BLPOC_RST_RESOL_OUT);
      chk(ph, 1'b0); chk(hs, 3'h0);
      stop_test;
   end
endmodule
